// [rtl/led_link_defines.svh]
// constants shared by the sink-driver device model and its display controller
// assumes pclk at 40 MHz on both ends and a 32-bit apb master on the controller
// ============================================================================
`ifndef LED_LINK_DEFINES_SVH
`define LED_LINK_DEFINES_SVH

// ============================================================================
// configuration fields
`define CFG_THR_HI   15
`define CFG_THR_LO   14
`define CFG_MODE_OE  13
`define CFG_MODE_LE  12
`define CFG_GAIN_HI  5
`define CFG_GAIN_LO  0
`define CFG_RESET    16'h602b
`define THERM_HOT    16'h7fff
`define THERM_COOL   16'hffff
`define ALL_ONES     16'hffff

// ============================================================================
// timing
`define CLK_NS       25
`define INMSG_NS     300
`define FORCED_NS    500
`define SETTLE_NS    700
`define REPORT_NS    100
`define INMSG_CYC    ((`INMSG_NS + `CLK_NS - 1) / `CLK_NS)
`define FORCED_CYC   ((`FORCED_NS + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_CYC   ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define REPORT_CYC   ((`REPORT_NS + `CLK_NS - 1) / `CLK_NS)
`define SYNC_MARGIN  6

// ============================================================================
// controller registers
`define REG_CTRL     8'h00
`define REG_TX       8'h04
`define REG_RX       8'h08
`define REG_STAT     8'h0c
`define REG_OE       8'h10
`define CTRL_START   8

`endif

// [rtl/led_link_pkg.sv]
// types shared by the sink-driver device model and its display controller
// assumes led_link_defines.svh for all numeric constants
package led_link_pkg;
	typedef logic [15:0] word_t;

	typedef enum logic [2:0] {
		CMD_LATCH  = 3'h0,
		CMD_OPEN   = 3'h1,
		CMD_SHORT  = 3'h2,
		CMD_THERM  = 3'h3,
		CMD_CONFIG = 3'h4
	} cmd_e;

	typedef enum logic [2:0] {
		DEV_IDLE   = 3'b001,
		DEV_REPORT = 3'b010,
		DEV_FORCED = 3'b100
	} dev_state_e;

	typedef enum logic [3:0] {
		CTL_IDLE   = 4'b0001,
		CTL_SHIFT  = 4'b0010,
		CTL_STROBE = 4'b0100,
		CTL_WAIT   = 4'b1000
	} ctl_state_e;
endpackage : led_link_pkg

// [rtl/led_link_if.sv]
// serial link between display controller and sink driver
// assumes both ends clocked by their own pclk; no clock lives in here
`timescale 1ns/1ps
interface led_link_if;
	logic serial_in;
	logic shift_clk;
	logic latch_strobe;
	logic output_enable_n;
	logic serial_out;

	modport device (
		input  serial_in,
		input  shift_clk,
		input  latch_strobe,
		input  output_enable_n,
		output serial_out
	);
	modport controller (
		output serial_in,
		output shift_clk,
		output latch_strobe,
		output output_enable_n,
		input  serial_out
	);
endinterface : led_link_if

// [rtl/led_sink_device.sv]
// control logic of the 16-channel sink driver: commands, detection, configuration
// assumes link pins and fault comparator levels arrive asynchronously to pclk
`timescale 1ns/1ps
`include "led_link_defines.svh"
module led_sink_device #(
	parameter int REPORT_CYC = `REPORT_CYC,
	parameter int INMSG_CYC  = `INMSG_CYC,
	parameter int FORCED_CYC = `FORCED_CYC
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	led_link_if.device              link,
	input  wire led_link_pkg::word_t fault_open,
	input  wire led_link_pkg::word_t fault_short,
	input  wire logic               overheat,
	output led_link_pkg::word_t     channel_on,
	output logic                    test_current,
	output logic [1:0]              short_thr_sel,
	output logic [5:0]              current_gain
);
	import led_link_pkg::*;

	generate
		if (REPORT_CYC < 1 || INMSG_CYC < 1 || FORCED_CYC < 1 || INMSG_CYC > 255
			|| REPORT_CYC > 255 || FORCED_CYC > 255) begin : bad_param
			$error("led_sink_device: counts must be 1..255");
		end
	endgenerate

	// ========================================================================
	// input synchronisers
	localparam int SW = 37;
	logic [SW-1:0] sync1_reg;
	logic [SW-1:0] sync2_reg;
	logic [3:0]    prev_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= 4'h0;
		end else begin
			sync1_reg <= {overheat, fault_short, fault_open, link.serial_in,
				link.shift_clk, link.latch_strobe, link.output_enable_n};
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg[3:0];
		end
	end

	logic  oe_n;
	logic  strobe;
	logic  sclk;
	logic  sdata;
	word_t f_open;
	word_t f_short;
	logic  hot;
	logic  clk_rise;
	logic  strobe_fall;

	assign oe_n        = sync2_reg[0];
	assign strobe      = sync2_reg[1];
	assign sclk        = sync2_reg[2];
	assign sdata       = sync2_reg[3];
	assign f_open      = sync2_reg[19:4];
	assign f_short     = sync2_reg[35:20];
	assign hot         = sync2_reg[36];
	assign clk_rise    = sclk & ~prev_reg[2];
	assign strobe_fall = ~strobe & prev_reg[1];

	// ========================================================================
	// command decode from edges under strobe
	logic [2:0] edge_cnt_reg;
	cmd_e       cmd;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_cnt_reg <= 3'h0;
		end else if (strobe_fall) begin
			edge_cnt_reg <= 3'h0;
		end else if (clk_rise && strobe && edge_cnt_reg != 3'h7) begin
			edge_cnt_reg <= edge_cnt_reg + 3'h1;
		end
	end

	assign cmd = cmd_e'(edge_cnt_reg);

	// ========================================================================
	// shift register, output latch, configuration
	word_t shift_reg;
	word_t latch_reg;
	word_t cfg_reg;
	logic  out_reg;
	logic  load_reg;
	word_t load_val_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_reg <= '0;
		end else if (load_reg) begin
			shift_reg <= load_val_reg;
		end else if (clk_rise && !strobe) begin
			shift_reg <= {shift_reg[14:0], sdata};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_reg <= 1'b0;
		end else begin
			out_reg <= shift_reg[15];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_reg <= '0;
		end else if (strobe_fall && cmd == CMD_LATCH) begin
			latch_reg <= shift_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= `CFG_RESET;
		end else if (strobe_fall && cmd == CMD_CONFIG) begin
			cfg_reg <= shift_reg;
		end
	end

	logic [1:0] mode;
	assign mode = cfg_reg[`CFG_MODE_OE:`CFG_MODE_LE];

	// ========================================================================
	// in-message detection
	logic [7:0] oe_low_cnt_reg;
	word_t      err_reg;
	logic       qualified;
	logic       test_now;
	word_t      hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_low_cnt_reg <= 8'h0;
		end else if (oe_n) begin
			oe_low_cnt_reg <= 8'h0;
		end else if (oe_low_cnt_reg != 8'hff) begin
			oe_low_cnt_reg <= oe_low_cnt_reg + 8'h1;
		end
	end

	assign qualified = !oe_n && oe_low_cnt_reg >= 8'(INMSG_CYC);
	assign test_now  = qualified && (mode[1] || (mode[0] && strobe_fall));
	assign hit       = test_now ? (latch_reg & (f_open | f_short)) : '0;

	dev_state_e state_reg;
	logic       report_go;
	assign report_go = state_reg == DEV_REPORT && load_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_reg <= `ALL_ONES;
		end else if (report_go) begin
			err_reg <= `ALL_ONES & ~hit;
		end else begin
			err_reg <= err_reg & ~hit;
		end
	end

	// ========================================================================
	// command sequencer
	logic [7:0] timer_reg;
	logic       therm_reg;
	logic       use_short_reg;
	logic       abort_reg;
	word_t      forced_res;

	// open verdict comes from the fault_open comparator input
	assign forced_res = (abort_reg || !oe_n) ? `ALL_ONES
		: ~(use_short_reg ? f_short : f_open);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg     <= DEV_IDLE;
			timer_reg     <= 8'h0;
			therm_reg     <= 1'b0;
			use_short_reg <= 1'b0;
			abort_reg     <= 1'b0;
			load_reg      <= 1'b0;
			load_val_reg  <= '0;
		end else begin
			load_reg <= 1'b0;
			case (state_reg)
				DEV_IDLE: begin
					timer_reg <= 8'h0;
					abort_reg <= 1'b0;
					if (strobe_fall) begin
						if (cmd == CMD_LATCH && mode != 2'b00) begin
							therm_reg <= 1'b0;
							state_reg <= DEV_REPORT;
						end else if (cmd == CMD_THERM) begin
							therm_reg <= 1'b1;
							load_val_reg <= hot ? `THERM_HOT : `THERM_COOL;
							state_reg <= DEV_REPORT;
						end else if ((cmd == CMD_OPEN || cmd == CMD_SHORT) && oe_n) begin
							use_short_reg <= cmd == CMD_SHORT;
							state_reg <= DEV_FORCED;
						end
					end
				end
				DEV_REPORT: begin
					if (load_reg) begin
						state_reg <= DEV_IDLE;
					end else if (timer_reg == 8'(REPORT_CYC - 1)) begin
						if (!therm_reg) begin
							load_val_reg <= err_reg & ~hit;
						end
						load_reg <= 1'b1;
					end else begin
						timer_reg <= timer_reg + 8'h1;
					end
				end
				DEV_FORCED: begin
					if (!oe_n) begin
						abort_reg <= 1'b1;
					end
					if (timer_reg == 8'(FORCED_CYC - 1)) begin
						load_val_reg <= forced_res;
						load_reg     <= 1'b1;
						state_reg    <= DEV_IDLE;
					end else begin
						timer_reg <= timer_reg + 8'h1;
					end
				end
				default: begin
					state_reg <= DEV_IDLE;
				end
			endcase
		end
	end

	// ========================================================================
	// outputs
	word_t chan_reg;
	logic  test_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_reg <= '0;
			test_reg <= 1'b0;
		end else begin
			test_reg <= state_reg == DEV_FORCED && !abort_reg && oe_n;
			if (state_reg == DEV_FORCED && !abort_reg && oe_n) begin
				chan_reg <= `ALL_ONES;
			end else begin
				chan_reg <= oe_n ? '0 : latch_reg;
			end
		end
	end

	assign channel_on      = chan_reg;
	assign test_current    = test_reg;
	assign link.serial_out = out_reg;
	assign short_thr_sel   = cfg_reg[`CFG_THR_HI:`CFG_THR_LO];
	assign current_gain    = cfg_reg[`CFG_GAIN_HI:`CFG_GAIN_LO];
endmodule : led_sink_device

// [rtl/led_display_ctrl.sv]
// display controller end: apb registers drive one link command per start
// assumes an apb master on pclk and a sink driver at the far end of the link
`timescale 1ns/1ps
`include "led_link_defines.svh"
module led_display_ctrl #(
	parameter int HALF_CYC = 4
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	led_link_if.controller   link
);
	import led_link_pkg::*;

	generate
		if (HALF_CYC < 4 || HALF_CYC > 255) begin : bad_param
			$error("led_display_ctrl: HALF_CYC must be 4..255");
		end
	endgenerate

	// ========================================================================
	// apb slave
	logic [2:0] cmd_reg;
	word_t      tx_reg;
	word_t      rx_reg;
	logic       oe_on_reg;
	logic       busy_reg;
	logic       go;
	logic       mapped;
	logic [31:0] rd_mux;
	logic        ready_reg;
	logic [31:0] rdata_reg;
	logic        err_reg;

	assign mapped = paddr == `REG_CTRL || paddr == `REG_TX || paddr == `REG_RX
		|| paddr == `REG_STAT || paddr == `REG_OE;
	assign go = psel && penable && ready_reg && pwrite && paddr == `REG_CTRL
		&& pwdata[`CTRL_START] && !busy_reg;

	always_comb begin
		rd_mux = 32'h0;
		case (paddr)
			`REG_CTRL: rd_mux = {29'h0, cmd_reg};
			`REG_TX:   rd_mux = {16'h0, tx_reg};
			`REG_RX:   rd_mux = {16'h0, rx_reg};
			`REG_STAT: rd_mux = {31'h0, busy_reg};
			`REG_OE:   rd_mux = {31'h0, oe_on_reg};
			default:   rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_reg <= 1'b0;
			rdata_reg <= 32'h0;
			err_reg   <= 1'b0;
		end else begin
			ready_reg <= psel && !penable;
			rdata_reg <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
			err_reg   <= psel && !penable && !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg   <= 3'h0;
			tx_reg    <= '0;
			oe_on_reg <= 1'b0;
		end else if (psel && penable && ready_reg && pwrite && !busy_reg) begin
			case (paddr)
				`REG_CTRL: cmd_reg   <= pwdata[2:0];
				`REG_TX:   tx_reg    <= pwdata[15:0];
				`REG_OE:   oe_on_reg <= pwdata[0];
				default:   cmd_reg   <= cmd_reg;
			endcase
		end
	end

	assign prdata  = rdata_reg;
	assign pready  = ready_reg;
	assign pslverr = err_reg;

	// ========================================================================
	// link sequencer
	logic       so1_reg;
	logic       so2_reg;
	ctl_state_e state_reg;
	logic [7:0] phase_reg;
	logic [4:0] bits_reg;
	logic [7:0] wait_reg;
	word_t      sh_reg;
	logic       sclk_reg;
	logic       strobe_reg;
	logic       oen_reg;
	logic       forced;
	logic       tick;

	assign forced = cmd_reg == CMD_OPEN || cmd_reg == CMD_SHORT;
	assign tick   = phase_reg == 8'(HALF_CYC - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			so1_reg <= 1'b0;
			so2_reg <= 1'b0;
		end else begin
			so1_reg <= link.serial_out;
			so2_reg <= so1_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oen_reg <= 1'b1;
		end else begin
			oen_reg <= !(oe_on_reg && !(busy_reg && forced));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= CTL_IDLE;
			phase_reg  <= 8'h0;
			bits_reg   <= 5'h0;
			wait_reg   <= 8'h0;
			sh_reg     <= '0;
			rx_reg     <= '0;
			sclk_reg   <= 1'b0;
			strobe_reg <= 1'b0;
			busy_reg   <= 1'b0;
		end else begin
			phase_reg <= tick ? 8'h0 : phase_reg + 8'h1;
			case (state_reg)
				CTL_IDLE: begin
					phase_reg <= 8'h0;
					if (go) begin
						busy_reg  <= 1'b1;
						sh_reg    <= tx_reg;
						bits_reg  <= 5'h0;
						state_reg <= CTL_SHIFT;
					end
				end
				CTL_SHIFT: begin
					if (tick && !sclk_reg) begin
						sclk_reg <= 1'b1;
						rx_reg   <= {rx_reg[14:0], so2_reg};
					end else if (tick) begin
						sclk_reg <= 1'b0;
						sh_reg   <= {sh_reg[14:0], 1'b0};
						bits_reg <= bits_reg + 5'h1;
						if (bits_reg == 5'hf) begin
							strobe_reg <= 1'b1;
							wait_reg   <= {5'h0, cmd_reg};
							state_reg  <= CTL_STROBE;
						end
					end
				end
				CTL_STROBE: begin
					if (tick && sclk_reg) begin
						sclk_reg <= 1'b0;
						wait_reg <= wait_reg - 8'h1;
					end else if (tick && wait_reg != 8'h0) begin
						sclk_reg <= 1'b1;
					end else if (tick) begin
						strobe_reg <= 1'b0;
						wait_reg   <= forced ? 8'(`SETTLE_CYC)
							: 8'(`REPORT_CYC + `SYNC_MARGIN);
						state_reg  <= CTL_WAIT;
					end
				end
				CTL_WAIT: begin
					if (wait_reg == 8'h0) begin
						busy_reg  <= 1'b0;
						state_reg <= CTL_IDLE;
					end else begin
						wait_reg <= wait_reg - 8'h1;
					end
				end
				default: begin
					state_reg <= CTL_IDLE;
				end
			endcase
		end
	end

	assign link.serial_in       = sh_reg[15];
	assign link.shift_clk       = sclk_reg;
	assign link.latch_strobe    = strobe_reg;
	assign link.output_enable_n = oen_reg;
endmodule : led_display_ctrl

// [test/led_link_monitor.sv]
// checker of the serial link between display controller and sink driver
// assumes both link ends are design modules sampled on one pclk
`timescale 1ns/1ps
`include "led_link_defines.svh"
module led_link_monitor #(
	parameter int HALF_CYC = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic serial_in,
	input wire logic shift_clk,
	input wire logic latch_strobe,
	input wire logic output_enable_n,
	input wire logic serial_out
);
	localparam int SETTLE = `SETTLE_CYC;
	logic       clk_q;
	logic       stb_q;
	logic [2:0] edge_cnt;
	logic [7:0] high_cnt;
	logic [5:0] quiet;
	logic       forced_fall;

	assign forced_fall = stb_q && !latch_strobe && (edge_cnt == 3'h1 || edge_cnt == 3'h2);

	// ========================================================================
	// helper state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_q <= 1'b0;
			stb_q <= 1'b0;
		end else begin
			clk_q <= shift_clk;
			stb_q <= latch_strobe;
		end
	end
	// clock rises counted under the strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			edge_cnt <= 3'h0;
		else if (latch_strobe && !stb_q)
			edge_cnt <= 3'h0;
		else if (latch_strobe && shift_clk && !clk_q)
			edge_cnt <= edge_cnt + 3'h1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			high_cnt <= 8'h0;
		else if (shift_clk)
			high_cnt <= high_cnt + 8'h1;
		else
			high_cnt <= 8'h0;
	end
	// settle window after a forced detection starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			quiet <= 6'h0;
		else if (forced_fall)
			quiet <= 6'(SETTLE);
		else if (quiet != 6'h0)
			quiet <= quiet - 6'h1;
	end

	// ========================================================================
	// assertions
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_shift_data_held: assert property ($rose(shift_clk) |-> $stable(serial_in))
		else $error("serial_in moved at shift clock rise");
	a_clk_high_width: assert property ($fell(shift_clk) |-> high_cnt == HALF_CYC)
		else $error("shift clock high phase has wrong length");
	a_cmd_edge_max: assert property (edge_cnt <= 3'h4)
		else $error("more than four clock rises under strobe");
	a_strobe_clk_low: assert property ($changed(latch_strobe) |-> !shift_clk)
		else $error("strobe changed while shift clock high");
	a_strobe_bounded: assert property ($rose(latch_strobe) |-> ##[1:48] !latch_strobe)
		else $error("strobe held too long");
	a_out_frozen: assert property (latch_strobe [*3] |-> $stable(serial_out))
		else $error("serial_out shifted while strobe high");
	a_report_wait: assert property ($fell(latch_strobe) && !forced_fall |-> !shift_clk [*8])
		else $error("shift clock before report was loaded");
	a_forced_oe_high: assert property (forced_fall |-> output_enable_n)
		else $error("forced detection started with outputs enabled");
	a_forced_oe_hold: assert property (quiet > 6'd6 |-> output_enable_n)
		else $error("output enable low during forced detection");
	a_forced_quiet: assert property ($rose(shift_clk) |-> quiet == 6'd0)
		else $error("shift clock inside forced detection window");
endmodule : led_link_monitor

// [test/tb_led_sink_error_detect_config.sv]
// testbench: apb-driven controller facing the sink driver over the link
// assumes design defaults; fault comparators and overheat driven here
`timescale 1ns/1ps
`include "led_link_defines.svh"
module tb_led_sink_error_detect_config;
	import led_link_pkg::*;
	logic        pclk;
	logic        presetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	word_t       fault_open;
	word_t       fault_short;
	logic        overheat;
	word_t       channel_on;
	logic        test_current;
	logic [1:0]  short_thr_sel;
	logic [5:0]  current_gain;
	logic        tc_seen;
	int          mismatches;
	int          compares;

	led_link_if link ();
	led_sink_device led_sink_device_i (.pclk(pclk), .presetn(presetn), .link(link),
		.fault_open(fault_open), .fault_short(fault_short), .overheat(overheat),
		.channel_on(channel_on), .test_current(test_current),
		.short_thr_sel(short_thr_sel), .current_gain(current_gain));
	led_display_ctrl #(.HALF_CYC(4)) led_display_ctrl_i (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	led_link_monitor #(.HALF_CYC(4)) led_link_monitor_i (.pclk(pclk), .presetn(presetn),
		.serial_in(link.serial_in), .shift_clk(link.shift_clk),
		.latch_strobe(link.latch_strobe), .output_enable_n(link.output_enable_n),
		.serial_out(link.serial_out));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) if (test_current === 1'b1) tc_seen <= 1'b1;

	// ========================================================================
	// shared tasks
	task give_verdict;
		if (mismatches == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task set_oe(input logic v);
		logic [31:0] s;
		logic        e;
		apb(`REG_OE, 1'b1, {31'h0, v}, s, e);
	endtask : set_oe

	// one link command; returns what was read back during its shift
	task run(input logic [2:0] cmd, input logic [15:0] tx, output logic [31:0] r);
		logic [31:0] s;
		logic        e;
		apb(`REG_TX, 1'b1, {16'h0, tx}, s, e);
		apb(`REG_CTRL, 1'b1, {23'h0, 1'b1, 5'h0, cmd}, s, e);
		s = 32'h1;
		while (s[0] !== 1'b0) begin
			apb(`REG_STAT, 1'b0, 32'h0, s, e);
		end
		apb(`REG_RX, 1'b0, 32'h0, r, e);
	endtask : run

	task wait_on(input word_t exp);
		int n;
		n = 0;
		while (channel_on !== exp && n < 20) begin
			@(posedge pclk);
			n++;
		end
		check(channel_on, exp);
	endtask : wait_on

	// ========================================================================
	// scenarios
	task t_reset;
		logic [31:0] s;
		logic        e;
		check(short_thr_sel, 2'b01);
		check(current_gain, 6'h2b);
		check(channel_on, 16'h0);
		apb(8'h40, 1'b0, 32'h0, s, e);
		check(e, 1'b1);
		check(s, 32'h0);
	endtask : t_reset

	task t_config;
		logic [31:0] r;
		for (int i = 0; i < 4; i++) begin
			run(3'h4, {i[1:0], 14'h0005}, r);
			check(short_thr_sel, i[1:0]);
			check(current_gain, 6'h05);
		end
	endtask : t_config

	task t_pass;
		logic [31:0] r;
		set_oe(1'b1);
		run(3'h0, 16'ha5a5, r);
		check(r, 32'hc005);
		wait_on(16'ha5a5);
		set_oe(1'b0);
		wait_on(16'h0);
		set_oe(1'b1);
	endtask : t_pass

	task t_therm;
		logic [31:0] r;
		overheat <= 1'b1;
		run(3'h3, 16'h1234, r);
		overheat <= 1'b0;
		run(3'h3, 16'h5678, r);
		check(r, 32'h7fff);
		check(channel_on, 16'ha5a5);
		run(3'h3, 16'h9abc, r);
		check(r, 32'hffff);
	endtask : t_therm

	task t_forced;
		logic [31:0] r;
		fault_open <= 16'h0101;
		tc_seen <= 1'b0;
		run(3'h1, 16'h0, r);
		check(tc_seen, 1'b1);
		run(3'h3, 16'h0, r);
		check(r, 32'hfefe);
		fault_open <= 16'h0;
		fault_short <= 16'h8000;
		run(3'h2, 16'h0, r);
		run(3'h3, 16'h0, r);
		check(r, 32'h7fff);
		check(channel_on, 16'ha5a5);
		fault_short <= 16'h0;
	endtask : t_forced

	task t_inmsg;
		logic [31:0] r;
		set_oe(1'b0);
		run(3'h4, 16'h202b, r);
		check(short_thr_sel, 2'b00);
		fault_open <= 16'h0f0f;
		fault_short <= 16'h1000;
		run(3'h0, 16'h00ff, r);
		set_oe(1'b1);
		repeat (40) @(posedge pclk);
		run(3'h0, 16'h00ff, r);
		set_oe(1'b0);
		run(3'h0, 16'h0, r);
		check(r, 32'hfff0);
		// strobe-only trigger: faults seen while oe low alone must not count
		run(3'h4, 16'h102b, r);
		set_oe(1'b1);
		run(3'h0, 16'h00ff, r);
		repeat (40) @(posedge pclk);
		fault_open <= 16'h0;
		fault_short <= 16'h0;
		run(3'h0, 16'h00ff, r);
		fault_open <= 16'h0f0f;
		run(3'h0, 16'h0, r);
		check(r, 32'hffff);
		run(3'h0, 16'h0, r);
		check(r, 32'hfff0);
	endtask : t_inmsg

	// ========================================================================
	// main sequence and watchdog
	initial begin
		presetn = 1'b0;
		paddr = 8'h0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		fault_open = 16'h0;
		fault_short = 16'h0;
		overheat = 1'b0;
		tc_seen = 1'b0;
		mismatches = 0;
		compares = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_config;
		t_pass;
		t_therm;
		t_forced;
		t_inmsg;
		give_verdict;
	end
	initial begin
		repeat (40000) @(posedge pclk);
		mismatches++;
		give_verdict;
	end
endmodule : tb_led_sink_error_detect_config
